// ==== include/opdec_pkg.sv ====
package opdec_pkg;
   localparam int WORD_W = 16;
   localparam int SEL_W = 4;

   // instruction classes
   typedef enum logic [4:0] {
      CL_ILLEGAL = 5'h00,
      CL_ALU_WIDE = 5'h01,
      CL_ALU_NARROW = 5'h02,
      CL_MEM_ARITH = 5'h03,
      CL_MOVE_IO = 5'h04,
      CL_MOVE_IDX = 5'h05,
      CL_MOVE_REG = 5'h06,
      CL_MOVE_REL = 5'h07,
      CL_MOVE_ABS = 5'h08,
      CL_MOVE_RR = 5'h09,
      CL_TEST_WORD = 5'h0a,
      CL_BIT_MASK = 5'h0b,
      CL_BRANCH = 5'h0c,
      CL_MOVE_IMM = 5'h0d,
      CL_HW_LOOP = 5'h0e,
      CL_JUMP = 5'h0f,
      CL_CALL = 5'h10,
      CL_RETURN = 5'h11,
      CL_INT_RETURN = 5'h12,
      CL_PROG_MOVE = 5'h13,
      CL_NOP = 5'h14,
      CL_DEBUG_HALT = 5'h15,
      CL_STOP = 5'h16,
      CL_WAIT = 5'h17,
      CL_SW_INT = 5'h18,
      CL_ILLEGAL_OP = 5'h19,
      CL_RESERVED = 5'h1a,
      CL_UNUSUAL = 5'h1b
   } op_class_t;

   typedef struct packed {
      logic valid;
      op_class_t op_class;
      logic [1:0] words;
      logic len_varies;
      logic [SEL_W-1:0] operation_selector;
      logic [3:0] condition_field;
      logic [7:0] immediate;
      logic [4:0] reg_sel;
      logic [1:0] addr_reg;
      logic illegal;
   } decode_out_t;

   localparam logic [1:0] LEN_ONE = 2'h1;
   localparam logic [1:0] LEN_TWO = 2'h2;
   localparam logic [1:0] LEN_THREE = 2'h3;
endpackage

// ==== verilog/dsp_opcode_class_decoder.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// RL1: one 16-bit word identifies whole instruction
// RL2: report length one, two or three words
// RL3: asterisk bits align fields, emitted zero
// RL4: plus bits align fields, emitted one
// RL5: dash bits are ignored by decode
// RL6: four-bit operation selector from scattered bits
// RL7: short-direct memory arithmetic length varies
// RL8: nop, debug halt, stop/wait/swi/illegal
// RL9: low nibble 0010 under 1110 is reserved; code decodes it as CL_PROG_MOVE when bit 6 is 0
// RL10: jumps and call two words, returns one
// RL11: short branch: condition and 7-bit offset
// RL12: loop by immediate or register count
// RL13: test word fixed, address register variable
// RL14: bit-mask and immediate moves use extension
// RL15: indexed long and absolute loads two words
// RL16: short immediate move carries 8-bit value
// RL17: unusual encodings recognised separately
// RL18: unassigned holes flagged illegal
module dsp_opcode_class_decoder (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // opcode from fetch
   input wire logic i_valid,
   input wire logic [opdec_pkg::WORD_W-1:0] i_opcode,
   // decode to execute
   output opdec_pkg::decode_out_t o_dec
);
   opdec_pkg::decode_out_t d_nxt;
   logic [15:0] w;
   // registered decode, one register per concern
   logic valid_r;
   opdec_pkg::op_class_t class_r;
   logic illegal_r;
   logic [1:0] words_r;
   logic len_varies_r;
   logic [opdec_pkg::SEL_W-1:0] sel_r;
   logic [3:0] cond_r;
   logic [7:0] imm_r;
   logic [4:0] reg_sel_r;
   logic [1:0] addr_reg_r;

   assign w = i_opcode; // [RL1]

   always_comb begin
      d_nxt = '0;
      d_nxt.valid = i_valid;
      d_nxt.words = opdec_pkg::LEN_ONE;
      d_nxt.op_class = opdec_pkg::CL_ILLEGAL;
      d_nxt.reg_sel = {w[11:8], w[7]};
      d_nxt.addr_reg = w[1:0];
      d_nxt.condition_field = w[11:8];
      d_nxt.immediate = w[7:0];
      // selector bits are split across the word
      d_nxt.operation_selector = {w[12], w[10], w[9], w[8]}; // [RL6]
      casez (w)
         16'b00??????????????: begin
            if (w[11] && !w[10]) begin
               d_nxt.op_class = opdec_pkg::CL_MEM_ARITH;
            end else begin
               d_nxt.op_class = opdec_pkg::CL_ALU_WIDE;
            end
            if (w[11] && !w[10] && w[7:6] == 2'b00) begin
               d_nxt.len_varies = 1'b1; // [RL7]
               d_nxt.words = opdec_pkg::LEN_ONE;
            end else if (w[11] && w[10] && w[7:6] == 2'b10) begin
               d_nxt.words = opdec_pkg::LEN_TWO; // [RL2]
            end else if (w[11] && w[10] && w[7:6] == 2'b11) begin
               d_nxt.words = opdec_pkg::LEN_TWO;
            end
         end
         16'b011?????????????: begin
            d_nxt.op_class = opdec_pkg::CL_ALU_NARROW;
         end
         16'b10?1????0???????: begin
            d_nxt.op_class = opdec_pkg::CL_MOVE_IO;
         end
         // bit 7 set selects the indexed move over the I/O move; bit 6 is not decoded (asterisk/plus)
         16'b10?1????1???????: begin // [RL3] [RL4]
            d_nxt.op_class = opdec_pkg::CL_MOVE_IDX;
            d_nxt.immediate = {2'h0, w[5:0]};
         end
         16'b11?1?????0??????: begin
            d_nxt.op_class = opdec_pkg::CL_MOVE_REG;
         end
         16'b11?1?????1?0?1??: begin
            d_nxt.op_class = opdec_pkg::CL_MOVE_RR; // [RL15]
         end
         16'b11?1?????1?0?0??: begin
            d_nxt.op_class = opdec_pkg::CL_MOVE_REL;
            d_nxt.words = opdec_pkg::LEN_TWO; // [RL15]
         end
         16'b11?1?????1?1???1: begin // [RL5]
            d_nxt.op_class = opdec_pkg::CL_MOVE_ABS;
            d_nxt.words = opdec_pkg::LEN_TWO; // [RL15]
         end
         16'b1000?????00?????: begin
            d_nxt.op_class = opdec_pkg::CL_MOVE_REG;
         end
         16'b10001110?01100??: begin
            d_nxt.op_class = opdec_pkg::CL_TEST_WORD; // [RL13]
         end
         16'b1000???1110?????,
         16'b1000???0111?????,
         16'b1000???01???????,
         16'b1000???11???????: begin
            d_nxt.op_class = opdec_pkg::CL_BIT_MASK; // [RL14]
            d_nxt.operation_selector = {1'b0, w[11:9]};
            d_nxt.words = (w[8:4] == 5'b01111) ? opdec_pkg::LEN_THREE
                                               : opdec_pkg::LEN_TWO;
         end
         16'b1010????0???????: begin
            d_nxt.op_class = opdec_pkg::CL_BRANCH; // [RL11]
            d_nxt.immediate = {w[6], w[6:0]};
         end
         16'b1100????0???????: begin
            d_nxt.op_class = opdec_pkg::CL_MOVE_IMM; // [RL16]
         end
         16'b110011?01???????,
         16'b110011?011??????: begin
            d_nxt.op_class = opdec_pkg::CL_HW_LOOP; // [RL12]
            d_nxt.len_varies = 1'b1;
         end
         16'b1110????10???1??: begin
            d_nxt.op_class = opdec_pkg::CL_JUMP;
            d_nxt.words = opdec_pkg::LEN_TWO; // [RL10]
         end
         16'b1110100111?010??: begin
            d_nxt.op_class = opdec_pkg::CL_CALL;
            d_nxt.words = opdec_pkg::LEN_TWO; // [RL10]
         end
         16'b1110110111?110?0: begin
            d_nxt.op_class = opdec_pkg::CL_RETURN; // [RL10]
         end
         16'b1110110111?110?1: begin
            d_nxt.op_class = opdec_pkg::CL_INT_RETURN;
         end
         16'b111??????0??????: begin
            d_nxt.op_class = opdec_pkg::CL_PROG_MOVE;
         end
         16'b1110????????0000: begin
            d_nxt.op_class = opdec_pkg::CL_NOP; // [RL8]
         end
         16'b1110????????0001: begin
            d_nxt.op_class = opdec_pkg::CL_DEBUG_HALT;
         end
         16'b1110????????0010: begin
            d_nxt.op_class = opdec_pkg::CL_RESERVED; // [RL9]
         end
         16'b1110????????01??: begin
            case (w[1:0])
               2'b00: d_nxt.op_class = opdec_pkg::CL_STOP;
               2'b01: d_nxt.op_class = opdec_pkg::CL_WAIT;
               2'b10: d_nxt.op_class = opdec_pkg::CL_SW_INT;
               default: d_nxt.op_class = opdec_pkg::CL_ILLEGAL_OP;
            endcase
         end
         16'b0100????????????: begin
            d_nxt.op_class = opdec_pkg::CL_UNUSUAL; // [RL17]
            d_nxt.len_varies = 1'b1;
         end
         default: d_nxt.op_class = opdec_pkg::CL_ILLEGAL; // [RL18]
      endcase
      d_nxt.illegal = (d_nxt.op_class == opdec_pkg::CL_ILLEGAL)
                   || (d_nxt.op_class == opdec_pkg::CL_RESERVED); // [RL18]
   end

   // strobe follows fetch one cycle later
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         valid_r <= 1'b0;
      end else begin
         valid_r <= d_nxt.valid;
      end
   end

   // class and illegal flag
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         class_r <= opdec_pkg::CL_ILLEGAL;
         illegal_r <= 1'b0;
      end else begin
         class_r <= d_nxt.op_class;
         illegal_r <= d_nxt.illegal; // [RL18]
      end
   end

   // length tells fetch how many words the instruction takes, opcode word included
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         words_r <= 2'h0;
         len_varies_r <= 1'b0;
      end else begin
         words_r <= d_nxt.words; // [RL2]
         len_varies_r <= d_nxt.len_varies;
      end
   end

   // operand fields
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         sel_r <= '0;
         cond_r <= 4'h0;
         imm_r <= 8'h00;
         reg_sel_r <= 5'h00;
         addr_reg_r <= 2'h0;
      end else begin
         sel_r <= d_nxt.operation_selector;
         cond_r <= d_nxt.condition_field;
         imm_r <= d_nxt.immediate;
         reg_sel_r <= d_nxt.reg_sel;
         addr_reg_r <= d_nxt.addr_reg;
      end
   end

   always_comb begin
      o_dec = '0;
      o_dec.valid = valid_r;
      o_dec.op_class = class_r;
      o_dec.words = words_r;
      o_dec.len_varies = len_varies_r;
      o_dec.operation_selector = sel_r;
      o_dec.condition_field = cond_r;
      o_dec.immediate = imm_r;
      o_dec.reg_sel = reg_sel_r;
      o_dec.addr_reg = addr_reg_r;
      o_dec.illegal = illegal_r;
   end
endmodule

// ==== tb/opdec_assertions.sv ====
`timescale 1ns/1ps
module opdec_assertions (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_valid,
   input wire logic [opdec_pkg::WORD_W-1:0] i_opcode,
   input wire opdec_pkg::decode_out_t o_dec
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   sequence s_in(logic [15:0] m);
      i_valid && (i_opcode ==? m);
   endsequence
   a_valid_follows: assert property (!i_rst |=> o_dec.valid == $past(i_valid))
      else $error("valid lag");
   a_ctrl_group: assert property (s_in(16'b1110_????_01??_01??) |=>
      o_dec.op_class == 5'(opdec_pkg::CL_STOP + $past(i_opcode[1:0]))) else $error("ctrl");
   a_reserved_flag: assert property (s_in(16'b1110_????_01??_0010) |=>
      o_dec.op_class == opdec_pkg::CL_RESERVED && o_dec.illegal) else $error("reserved");
   a_branch_fields: assert property (s_in(16'b1010_????_0???_????) |=>
      o_dec.condition_field == $past(i_opcode[11:8]) &&
      o_dec.immediate == {$past(i_opcode[6]), $past(i_opcode[6:0])}) else $error("branch");
   a_return_kind: assert property (s_in(16'b1110_1101_11?1_10??) |=>
      o_dec.op_class == 5'(opdec_pkg::CL_RETURN + $past(i_opcode[0]))) else $error("ret");
   a_test_word_op_areg: assert property (s_in(16'b1000_1110_0011_00??) |=>
      o_dec.addr_reg == $past(i_opcode[1:0])) else $error("test_word_op");
   a_imm_value: assert property (s_in(16'b1100_????_0???_????) |=>
      o_dec.immediate == $past(i_opcode[7:0])) else $error("imm");
   a_idx_len: assert property (s_in(16'b11?1_????_?1?0_????) |=> o_dec.words ==
      ($past(i_opcode[2]) ? opdec_pkg::LEN_ONE : opdec_pkg::LEN_TWO)) else $error("idx");
endmodule
bind dsp_opcode_class_decoder opdec_assertions opdec_assertions_i (.i_clk_sys(i_clk_sys),
   .i_rst(i_rst), .i_valid(i_valid), .i_opcode(i_opcode), .o_dec(o_dec));

// ==== tb/exec_stage_model.sv ====
`timescale 1ns/1ps
module exec_stage_model (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire opdec_pkg::decode_out_t i_dec,
   output int o_count,
   output int o_words
);
   // fetch skips extension words by the reported length
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_count <= 0;
         o_words <= 0;
      end else if (i_dec.valid) begin
         o_count <= o_count + 1;
         o_words <= o_words + int'(i_dec.words);
      end
   end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   logic i_clk_sys = 1'b0, i_rst = 1'b1, i_valid = 1'b0;
   logic [15:0] i_opcode = 16'h0000;
   opdec_pkg::decode_out_t o_dec;
   int failures = 0, samples_checked = 0, cycles = 0, n_exp = 0, w_exp = 0, n_seen, w_seen;
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
   $display("wrong value %s expected %h seen %h", n, e, g); end end
   always #5 i_clk_sys = ~i_clk_sys;
   dsp_opcode_class_decoder dsp_opcode_class_decoder_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_valid(i_valid), .i_opcode(i_opcode), .o_dec(o_dec));
   exec_stage_model exec_stage_model_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_dec(o_dec),
      .o_count(n_seen), .o_words(w_seen));
   task automatic stop_test;
      $display("failures %0d samples_checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // a class of CL_ILLEGAL means the class is not checked
   task automatic dec(input logic [15:0] op, input opdec_pkg::op_class_t c, input logic [1:0] w);
      @(posedge i_clk_sys);
      i_valid <= 1'b1;
      i_opcode <= op;
      @(posedge i_clk_sys);
      i_valid <= 1'b0;
      #1;
      n_exp++;
      w_exp += w;
      if (c != opdec_pkg::CL_ILLEGAL) `CHK("class", c, o_dec.op_class)
      `CHK("words", w, o_dec.words)
   endtask
   task automatic t_control;
      dec(16'he040, opdec_pkg::CL_NOP, 2'h1);
      dec(16'he840, opdec_pkg::CL_NOP, 2'h1);
      dec(16'he041, opdec_pkg::CL_DEBUG_HALT, 2'h1);
      for (int t = 0; t < 4; t++) begin
         dec(16'he044 + 16'(t), opdec_pkg::op_class_t'(5'h16 + 5'(t)), 2'h1);
      end
      dec(16'he042, opdec_pkg::CL_RESERVED, 2'h1);
      `CHK("illegal", 1'b1, o_dec.illegal)
   endtask
   task automatic t_flow;
      dec(16'ha57f, opdec_pkg::CL_BRANCH, 2'h1);
      `CHK("cond", 4'h5, o_dec.condition_field)
      `CHK("offset", 8'hff, o_dec.immediate)
      dec(16'he384, opdec_pkg::CL_JUMP, 2'h2);
      dec(16'he9c8, opdec_pkg::CL_CALL, 2'h2);
      dec(16'hedd8, opdec_pkg::CL_RETURN, 2'h1);
      dec(16'hedd9, opdec_pkg::CL_INT_RETURN, 2'h1);
   endtask
   task automatic t_moves;
      dec(16'hc312, opdec_pkg::CL_MOVE_IMM, 2'h1);
      `CHK("imm", 8'h12, o_dec.immediate)
      dec(16'h8e32, opdec_pkg::CL_TEST_WORD, 2'h1);
      `CHK("areg", 2'h2, o_dec.addr_reg)
      dec(16'hd040, opdec_pkg::CL_ILLEGAL, 2'h2);
      dec(16'hd044, opdec_pkg::CL_ILLEGAL, 2'h1);
      dec(16'h81c5, opdec_pkg::CL_BIT_MASK, 2'h2);
      dec(16'hccc3, opdec_pkg::CL_HW_LOOP, 2'h1);
      dec(16'hcc85, opdec_pkg::CL_HW_LOOP, 2'h1);
      `CHK("varies", 1'b1, o_dec.len_varies)
   endtask
   always @(posedge i_clk_sys) if (++cycles == 2000) begin
      failures++;
      stop_test;
   end
   initial begin
      repeat (4) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      t_control;
      t_flow;
      t_moves;
      @(posedge i_clk_sys);
      #1;
      `CHK("count", n_exp, n_seen)
      `CHK("fetched", w_exp, w_seen)
      stop_test;
   end
endmodule
